/* File: rtl/uiw_pkg.sv */
// Purpose: Shared constants and carriers for the serial port interrupt and wake-up block
// Assumes: One 25 MHz system clock
// Notes:   Wake settle time is a parameter default of the top module
package uiw_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS      = 40;
  localparam int unsigned WAKE_SETTLE_NS     = 2_000;
  localparam int unsigned WAKE_SETTLE_CYCLES =
    (WAKE_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PULSE_NS           = 40;
  localparam int unsigned PULSE_CYCLES       =
    ((PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) < 1 ? 1 :
    ((PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // ---------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_BIT_NINE  = 8;
  localparam int unsigned ADDR_BIT_EIGHT = 7;
  localparam logic        IRQ_N_RESET    = 1'b1;
  localparam logic        PIN_RESET      = 1'b1;

  // Control bits from the second control register
  typedef struct packed {
    logic tx_empty_int_enable;
    logic tx_idle_int_enable;
    logic rx_int_enable;
    logic addr_detect_enable;
    logic pin_wake_enable;
    logic nine_bit_select;
    logic port_enable;
    logic receiver_enable;
  } uiw_ctrl_s;

  // Status flags from the status register
  typedef struct packed {
    logic tx_empty_flag;
    logic tx_idle_flag;
    logic rx_available_flag;
    logic overrun_flag;
  } uiw_flags_s;

  // Processor side enables
  typedef struct packed {
    logic global_int_enable;
    logic port_int_enable;
    logic stack_not_full;
  } uiw_cpu_s;

  typedef enum logic [1:0] {
    UIW_RUN    = 2'b00,
    UIW_ASLEEP = 2'b01,
    UIW_SETTLE = 2'b11
  } uiw_wake_e;

endpackage : uiw_pkg

/* File: rtl/uiw_edge.sv */
// Purpose: Rising edge detector for a status flag
// Assumes: Input synchronous to sys_clk
// Notes:   Output is a one-cycle pulse
`timescale 1ns/1ns
module uiw_edge
  import uiw_pkg::*;
(
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic sys_rst,
  input  wire logic clk_en,
  // Level in, pulse out
  input  wire logic level_in,
  output logic      rise_pulse
);

  typedef struct packed {
    logic last;
    logic rise;
  } uiw_edge_s;

  uiw_edge_s state_reg;
  uiw_edge_s state_next;

  always_comb begin
    state_next      = state_reg;
    state_next.rise = 1'b0;
    if (clk_en) begin
      state_next.rise = level_in & ~state_reg.last;
      state_next.last = level_in;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign rise_pulse = state_reg.rise;

endmodule : uiw_edge

/* File: rtl/uiw_pulse.sv */
// Purpose: Stretch a request into a low-going pulse of fixed width
// Assumes: Request is a one-cycle pulse
// Notes:   Requests during a pulse merge into it
`timescale 1ns/1ns
module uiw_pulse
  import uiw_pkg::*;
#(
  parameter int unsigned WIDTH = PULSE_CYCLES
)(
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic sys_rst,
  input  wire logic clk_en,
  // Request and pulse
  input  wire logic req,
  output logic      irq_n
);

  localparam int unsigned CW = $clog2(WIDTH + 1);

  typedef struct packed {
    logic [CW-1:0] count;
    logic          irq_n;
  } uiw_pulse_s;

  uiw_pulse_s state_reg;
  uiw_pulse_s state_next;

  always_comb begin
    state_next = state_reg;
    if (clk_en) begin
      if (req) begin
        state_next.count = CW'(WIDTH - 1);
        state_next.irq_n = 1'b0;
      end else if (state_reg.count != '0) begin
        state_next.count = state_reg.count - 1'b1;
      end else begin
        state_next.irq_n = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_reg.count <= '0;
      state_reg.irq_n <= IRQ_N_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  assign irq_n = state_reg.irq_n;

endmodule : uiw_pulse

/* File: rtl/uiw_top.sv */
// Purpose: Interrupt request and receive-pin wake-up logic of a serial port
// Assumes: Flags and received words come from the receiver and transmitter
// Notes:   module_clk_on low means the high-speed module clock is stopped
`timescale 1ns/1ns
module uiw_top
  import uiw_pkg::*;
#(
  parameter int unsigned SETTLE_CYCLES = WAKE_SETTLE_CYCLES,
  parameter int unsigned WORD_WIDTH    = 9
)(
  // Clock, reset, enable
  input  wire logic                  sys_clk,
  input  wire logic                  sys_rst,
  input  wire logic                  clk_en,
  // Module clock state
  input  wire logic                  module_clk_on,
  // Configuration
  input  wire uiw_ctrl_s             ctrl,
  input  wire logic                  parity_enable,
  input  wire uiw_cpu_s              cpu,
  // Status flags from the port
  input  wire uiw_flags_s            flags,
  input  wire logic [WORD_WIDTH-1:0] rx_word,
  // Serial pin
  input  wire logic                  serial_in_pin,
  // Interrupt and wake outputs
  output logic                       irq_n,
  output logic                       vector_take,
  output logic                       wake_event,
  output logic                       port_run,
  output logic                       rx_pin_gated,
  output logic                       addr_word,
  output logic                       mode_conflict
);

  localparam int unsigned SW = $clog2(SETTLE_CYCLES + 1);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    uiw_wake_e     wake;
    logic [SW-1:0] settle;
    logic          pin_last;
    logic          wake_pend;
    logic          req;
    logic          vector;
    logic          wake_evt;
    logic          run;
    logic          rx_gated;
    logic          addr;
    logic          conflict;
  } uiw_top_s;

  uiw_top_s state_reg;
  uiw_top_s state_next;

  logic rise_empty;
  logic rise_idle;
  logic rise_avail;
  logic rise_over;
  logic irq_pulse_n;

  // Top received bit by word size
  function automatic logic top_bit(input logic [WORD_WIDTH-1:0] w, input logic nine);
    top_bit = nine ? w[ADDR_BIT_NINE] : w[ADDR_BIT_EIGHT];
  endfunction : top_bit

  // ---------------------------------------------------------------
  // Flag edge detectors
  // ---------------------------------------------------------------
  // Edges freeze with the module clock; a flag that rises and falls again in power-down is never seen
  wire logic run_en = clk_en & module_clk_on;

  uiw_edge u_edge_empty (
    .sys_clk    (sys_clk),
    .sys_rst    (sys_rst),
    .clk_en     (run_en),
    .level_in   (flags.tx_empty_flag),
    .rise_pulse (rise_empty)
  );

  uiw_edge u_edge_idle (
    .sys_clk    (sys_clk),
    .sys_rst    (sys_rst),
    .clk_en     (run_en),
    .level_in   (flags.tx_idle_flag),
    .rise_pulse (rise_idle)
  );

  uiw_edge u_edge_avail (
    .sys_clk    (sys_clk),
    .sys_rst    (sys_rst),
    .clk_en     (run_en),
    .level_in   (flags.rx_available_flag),
    .rise_pulse (rise_avail)
  );

  uiw_edge u_edge_over (
    .sys_clk    (sys_clk),
    .sys_rst    (sys_rst),
    .clk_en     (run_en),
    .level_in   (flags.overrun_flag),
    .rise_pulse (rise_over)
  );

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  logic is_addr;
  logic src_empty;
  logic src_idle;
  logic src_avail;
  logic src_over;
  logic src_addr;
  logic src_wake;
  logic any_src;
  logic cpu_ok;
  logic wake_armed;
  logic pin_fall;

  always_comb begin
    state_next = state_reg;
    is_addr    = top_bit(rx_word, ctrl.nine_bit_select);
    // Flags are inputs only; nothing here can set or clear them
    src_empty  = rise_empty & ctrl.tx_empty_int_enable;
    src_idle   = rise_idle & ctrl.tx_idle_int_enable;
    src_avail  = rise_avail & ctrl.rx_int_enable
                 & (~ctrl.addr_detect_enable | is_addr);
    src_over   = rise_over & ctrl.rx_int_enable;
    src_addr   = rise_avail & ctrl.addr_detect_enable & is_addr;
    src_wake   = 1'b0;
    cpu_ok     = cpu.global_int_enable & cpu.port_int_enable;
    wake_armed = ctrl.pin_wake_enable & ctrl.port_enable
                 & ctrl.receiver_enable & ctrl.rx_int_enable;
    pin_fall   = state_reg.pin_last & ~serial_in_pin;
    state_next.wake_evt = 1'b0;
    state_next.req      = 1'b0;
    state_next.vector   = 1'b0;
    if (clk_en) begin
      state_next.pin_last = serial_in_pin;
      case (state_reg.wake)
        UIW_RUN: begin
          state_next.run = module_clk_on;
          if (!module_clk_on) begin
            state_next.wake = UIW_ASLEEP;
          end
        end
        UIW_ASLEEP: begin
          state_next.run = 1'b0;
          if (wake_armed && pin_fall) begin
            state_next.wake_evt  = 1'b1;
            state_next.wake_pend = cpu_ok;
            state_next.rx_gated  = 1'b1;
            state_next.settle    = SW'(SETTLE_CYCLES);
            state_next.wake      = UIW_SETTLE;
          end else if (module_clk_on) begin
            state_next.wake = UIW_RUN;
          end
        end
        UIW_SETTLE: begin
          if (state_reg.settle != '0) begin
            state_next.settle = state_reg.settle - 1'b1;
          end else if (module_clk_on) begin
            src_wake             = state_reg.wake_pend;
            state_next.wake_pend = 1'b0;
            state_next.rx_gated  = 1'b0;
            state_next.run       = 1'b1;
            state_next.wake      = UIW_RUN;
          end
        end
        default: begin
          state_next.wake = UIW_RUN;
        end
      endcase
      // Only the available and address sources drop with the clock off; gated words are dropped
      if (!run_en || state_reg.rx_gated) begin
        src_avail = 1'b0;
        src_addr  = 1'b0;
      end
      any_src = src_empty | src_idle | src_avail | src_over
                | src_addr | src_wake;
      state_next.req      = any_src;
      // Vector follows the registered request so it meets the low pulse
      state_next.vector   = state_reg.req & cpu_ok & cpu.stack_not_full;
      state_next.addr     = ctrl.addr_detect_enable & is_addr;
      state_next.conflict = ctrl.addr_detect_enable & parity_enable;
    end else begin
      any_src = 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_reg          <= '0;
      state_reg.wake     <= UIW_RUN;
      state_reg.pin_last <= PIN_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // ---------------------------------------------------------------
  // Request pulse
  // ---------------------------------------------------------------
  uiw_pulse u_pulse (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .clk_en  (clk_en),
    .req     (state_reg.req),
    .irq_n   (irq_pulse_n)
  );

  // is kept by software; port_run tells when a transfer may stop
  assign irq_n         = irq_pulse_n;
  assign vector_take   = state_reg.vector;
  assign wake_event    = state_reg.wake_evt;
  assign port_run      = state_reg.run;
  assign rx_pin_gated  = state_reg.rx_gated;
  assign addr_word     = state_reg.addr;
  assign mode_conflict = state_reg.conflict;

endmodule : uiw_top

/* File: verification/uiw_top_sva.sv */
// Purpose: Port assertions for the interrupt and wake-up block
// Assumes: Bound to uiw_top, one clock domain
// Notes:   Bind statement at the foot
`timescale 1ns/1ns
module uiw_top_sva
  import uiw_pkg::*;
#(
  parameter int unsigned SETTLE_CYCLES = WAKE_SETTLE_CYCLES,
  parameter int unsigned WORD_WIDTH    = 9
)(
  // Clock and control
  input wire logic                  sys_clk,
  input wire logic                  sys_rst,
  input wire logic                  clk_en,
  input wire logic                  module_clk_on,
  input wire uiw_ctrl_s             ctrl,
  input wire logic                  parity_enable,
  input wire uiw_cpu_s              cpu,
  input wire uiw_flags_s            flags,
  input wire logic [WORD_WIDTH-1:0] rx_word,
  input wire logic                  serial_in_pin,
  // Outputs
  input wire logic                  irq_n,
  input wire logic                  vector_take,
  input wire logic                  wake_event,
  input wire logic                  port_run,
  input wire logic                  rx_pin_gated,
  input wire logic                  addr_word,
  input wire logic                  mode_conflict
);
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  a_pulse_one: assert property ($fell(irq_n) |=> irq_n)
    else $error("request pulse too long");
  a_vector_irq: assert property (vector_take |-> !irq_n)
    else $error("vector without request");
  a_vector_enables: assert property (vector_take |->
    cpu.global_int_enable && cpu.port_int_enable && cpu.stack_not_full)
    else $error("vector with enables clear");
  a_conflict_flag: assert property ($past(clk_en && !sys_rst) |->
    mode_conflict == $past(ctrl.addr_detect_enable && parity_enable))
    else $error("mode conflict wrong");
  a_addr_top_bit: assert property ($past(clk_en && !sys_rst) |->
    addr_word == $past(ctrl.addr_detect_enable &&
    (ctrl.nine_bit_select ? rx_word[8] : rx_word[7])))
    else $error("address word wrong");
  a_wake_gates: assert property (wake_event |-> rx_pin_gated)
    else $error("wake without gating");
  a_wake_armed: assert property (wake_event |-> $past(!module_clk_on &&
    ctrl.pin_wake_enable && ctrl.port_enable && ctrl.receiver_enable && ctrl.rx_int_enable))
    else $error("wake not armed");
  a_settle_quiet: assert property (rx_pin_gated |-> irq_n)
    else $error("request during settle");
  a_stop_halts: assert property ($past(!module_clk_on && clk_en && !sys_rst) |->
    !port_run)
    else $error("port runs with clock off");
endmodule : uiw_top_sva

bind uiw_top uiw_top_sva #(.SETTLE_CYCLES(SETTLE_CYCLES), .WORD_WIDTH(WORD_WIDTH)) i_sva (
  .sys_clk, .sys_rst, .clk_en, .module_clk_on, .ctrl, .parity_enable, .cpu, .flags,
  .rx_word, .serial_in_pin, .irq_n, .vector_take, .wake_event, .port_run,
  .rx_pin_gated, .addr_word, .mode_conflict);

/* File: verification/uiw_far_model.sv */
// Purpose: Processor side counter and remote transmitter start bit
// Assumes: Same clock as the block
// Notes:   Pin idles high
`timescale 1ns/1ns
module uiw_far_model
  import uiw_pkg::*;
(
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic sys_rst,
  // Block outputs
  input  wire logic irq_n,
  input  wire logic vector_take,
  input  wire logic wake_event,
  // Pin side
  input  wire logic send_start,
  output logic      serial_in_pin,
  // Event counts
  output logic [7:0] irq_cnt,
  output logic [7:0] vec_cnt,
  output logic [7:0] wake_cnt
);
  logic [2:0] low_left;
  logic       irq_last;
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      {irq_cnt, vec_cnt, wake_cnt} <= '0;
      low_left <= 3'h0;
      irq_last <= 1'b1;
    end else begin
      irq_last <= irq_n;
      if (irq_last && !irq_n) irq_cnt <= irq_cnt + 8'h01;
      if (vector_take) vec_cnt <= vec_cnt + 8'h01;
      if (wake_event) wake_cnt <= wake_cnt + 8'h01;
      if (send_start) low_left <= 3'h4;
      else if (low_left != 3'h0) low_left <= low_left - 3'h1;
    end
  end
  assign serial_in_pin = (low_left == 3'h0);
endmodule : uiw_far_model

/* File: verification/uart_interrupt_wakeup_tb_top.sv */
// Purpose: Directed bench for the interrupt and wake-up block
// Assumes: Short settle parameter
// Notes:   Counts come from the far side model
`timescale 1ns/1ns
module uart_interrupt_wakeup_tb_top;
  import uiw_pkg::*;
  localparam int unsigned SETTLE = 3;
  logic       sys_clk, sys_rst, clk_en, module_clk_on, parity_enable, send_start;
  uiw_ctrl_s  ctrl;
  uiw_cpu_s   cpu;
  uiw_flags_s flags;
  logic [8:0] rx_word;
  logic       serial_in_pin, irq_n, vector_take, wake_event, port_run;
  logic       rx_pin_gated, addr_word, mode_conflict;
  logic [7:0] irq_cnt, vec_cnt, wake_cnt;
  int         err_count, comparisons;
  logic [24:0] tbl [12] = '{
    {4'h8, 8'h80, 9'h000, 4'h1}, {4'h8, 8'h7f, 9'h000, 4'h0},
    {4'h4, 8'h40, 9'h000, 4'h1}, {4'h4, 8'hbf, 9'h000, 4'h0},
    {4'h2, 8'h20, 9'h000, 4'h1}, {4'h1, 8'h20, 9'h000, 4'h1},
    {4'h2, 8'hdf, 9'h000, 4'h0}, {4'h2, 8'h34, 9'h100, 4'h1},
    {4'h2, 8'h34, 9'h080, 4'h0}, {4'h2, 8'h30, 9'h080, 4'h1},
    {4'h2, 8'h30, 9'h100, 4'h0}, {4'hf, 8'he0, 9'h000, 4'h1}};

  uiw_top #(.SETTLE_CYCLES(SETTLE), .WORD_WIDTH(9)) i_dut (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(clk_en), .module_clk_on(module_clk_on),
    .ctrl(ctrl), .parity_enable(parity_enable), .cpu(cpu), .flags(flags),
    .rx_word(rx_word), .serial_in_pin(serial_in_pin), .irq_n(irq_n),
    .vector_take(vector_take), .wake_event(wake_event), .port_run(port_run),
    .rx_pin_gated(rx_pin_gated), .addr_word(addr_word), .mode_conflict(mode_conflict));
  uiw_far_model i_far (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .irq_n(irq_n), .vector_take(vector_take),
    .wake_event(wake_event), .send_start(send_start), .serial_in_pin(serial_in_pin),
    .irq_cnt(irq_cnt), .vec_cnt(vec_cnt), .wake_cnt(wake_cnt));

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : tally_and_finish

  task automatic run_case(input logic [24:0] t);
    logic [7:0] i0;
    logic [7:0] v0;
    i0 = irq_cnt;
    v0 = vec_cnt;
    ctrl <= uiw_ctrl_s'(t[20:13]);
    rx_word <= t[12:4];
    @(posedge sys_clk) flags <= uiw_flags_s'(t[24:21]);
    repeat (8) @(posedge sys_clk);
    flags <= '0;
    repeat (4) @(posedge sys_clk);
    chk(irq_cnt - i0, {4'h0, t[3:0]});
    chk(vec_cnt - v0, {4'h0, t[3:0]});
  endtask : run_case

  task automatic wake_try(input logic [7:0] c, input logic [2:0] u, input logic ew,
                          input logic [7:0] n);
    logic [7:0] i0;
    logic [7:0] w0;
    int         k;
    i0 = irq_cnt;
    w0 = wake_cnt;
    k = 0;
    ctrl <= uiw_ctrl_s'(c);
    cpu <= uiw_cpu_s'(u);
    module_clk_on <= 1'b0;
    repeat (3) @(posedge sys_clk);
    flags <= 4'h2;
    repeat (3) @(posedge sys_clk);
    flags <= '0;
    send_start <= 1'b1;
    @(posedge sys_clk) send_start <= 1'b0;
    while (ew && wake_cnt == w0 && k < 12) begin
      @(posedge sys_clk);
      k++;
    end
    if (k >= 12) begin
      err_count++;
      tally_and_finish;
    end
    repeat (2) @(posedge sys_clk);
    chk(wake_cnt - w0, {7'h00, ew});
    chk({7'h00, rx_pin_gated}, {7'h00, ew});
    chk({7'h00, port_run}, 8'h00);
    module_clk_on <= 1'b1;
    repeat (SETTLE + 10) @(posedge sys_clk);
    chk(irq_cnt - i0, n);
    chk({7'h00, port_run}, 8'h01);
    cpu <= uiw_cpu_s'(3'h7);
  endtask : wake_try

  // ---------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  initial begin
    {sys_rst, clk_en, module_clk_on} = 3'h7;
    {parity_enable, send_start} = 2'h0;
    ctrl = '0;
    cpu = uiw_cpu_s'(3'h7);
    flags = '0;
    rx_word = '0;
    err_count = 0;
    comparisons = 0;
    repeat (8) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    for (int i = 0; i < 12; i++) run_case(tbl[i]);
    ctrl <= uiw_ctrl_s'(8'h14);
    rx_word <= 9'h100;
    parity_enable <= 1'b1;
    repeat (2) @(posedge sys_clk);
    chk({7'h00, addr_word}, 8'h01);
    chk({7'h00, mode_conflict}, 8'h01);
    parity_enable <= 1'b0;
    wake_try(8'h2b, 3'h7, 1'b1, 8'h01);
    wake_try(8'h2b, 3'h3, 1'b1, 8'h00);
    wake_try(8'h23, 3'h7, 1'b0, 8'h00);
    tally_and_finish;
  end
endmodule : uart_interrupt_wakeup_tb_top
